/* File: src/wwat_top.sv */
// Purpose: watchdog timer with address trap, classic wishbone slave
// Assumes: fetch strobe and mode inputs synchronous to clk, fc equals clk
// Notes: requests leave as one-cycle pulses plus a stretched reset level
//
// Behaviour
// - watchdog counts right after reset
// - overflow gives reset or interrupt per action
// - pause in stop, idle; resume
// - clear code clears stages, not divider
// - time select picks overflow period
// - interrupt action cannot return to reset
// - config register write only, reads as zero
// - command codes clear, disable, commit trap
// - disable code works only with on bit low
// - disabled watchdog holds stages cleared
// - watchdog interrupt ignores master flag
// - new watchdog interrupt preempts, older pending
// - watchdog reset lasts at most 24 fc
// - ram trap enable needs commit code
// - special and buffer areas always trap
// - trap action selects interrupt or reset
// - trap interrupt non-maskable and preempting
// - trap reset lasts at most 24 fc
`timescale 1ns/1ps
`default_nettype none
`include "wwat_defs.svh"
module wwat_top #(
    parameter int DIV_W = 23, // fast tick exponent, shrink for simulation
    parameter int SLOW_SHIFT = 8, // fast/slow exponent difference
    parameter int FA_W = 16, // fetch address width
    parameter logic [15:0] RAM_LO = 16'h0040, // internal ram start
    parameter logic [15:0] RAM_HI = 16'h043f, // internal ram end
    parameter logic [15:0] SFR_LO = 16'h0000, // special register area start
    parameter logic [15:0] SFR_HI = 16'h003f, // special register area end
    parameter logic [15:0] DBR_LO = 16'h0f80, // data buffer area start
    parameter logic [15:0] DBR_HI = 16'h0fff // data buffer area end
) (
    input wire logic clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // clock and mode inputs
    input wire logic slow_prescale_sel,
    input wire logic low_speed_mode,
    input wire logic fs_tick,
    input wire logic stop_mode,
    input wire logic idle_mode,
    // instruction fetch watch
    input wire logic fetch_valid,
    input wire logic [FA_W-1:0] fetch_addr,
    // requests
    output logic wdog_irq,
    output logic wdog_rst_req,
    output logic trap_irq,
    output logic trap_rst_req,
    output logic sys_reset_out
);
    // ****************************************
    // register state
    // ****************************************
    logic wdog_on_bit; // software enable bit
    logic wdog_running; // counter actually enabled
    logic [1:0] detect_time_sel; // overflow period select
    logic overflow_action_sel; // 1 reset, 0 interrupt; one-way to 0
    logic trap_action_sel; // 1 reset, 0 interrupt
    logic ram_trap_pending; // written, not yet committed
    logic ram_trap_enable; // committed ram trap setting
    logic clear_pulse; // one-cycle clear toward the counter
    wwat_pkg::wwat_rst_state_t rst_state; // reset stretcher state
    logic [7:0] rst_cnt; // reset stretch cycles left
    localparam logic [7:0] CFG_RST = `WWAT_CFG_RESET; // config byte after reset
    wwat_cnt_if cif (); // carrier to the divider and binary stages, declared early for the status word

    // ****************************************
    // bus decode
    // ****************************************
    logic bus_req; // active request, not yet answered
    logic wr_fire; // write commits on the ack edge
    logic [7:0] wr_byte; // lane 0 data
    logic wr_cfg; // config write
    logic wr_cmd; // command write
    logic [7:0] status; // readable state

    // word index match, low address bits must be zero
    function automatic logic hit_idx(input logic [9:0] adr, input logic [7:0] idx);
        return (adr[9:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
        wr_byte = wb_dat_i[7:0];
        wr_cfg = wr_fire && hit_idx(wb_adr_i, `WWAT_IDX_CONFIG);
        wr_cmd = wr_fire && hit_idx(wb_adr_i, `WWAT_IDX_COMMAND);
    end

    // one-cycle ack, also for unmapped addresses so the master never hangs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // status word gathered from live state
    always_comb begin
        status = 8'h00;
        status[`WWAT_ST_RUN] = wdog_running;
        status[`WWAT_ST_ACT] = overflow_action_sel;
        status[`WWAT_ST_TRAP_ACT] = trap_action_sel;
        status[`WWAT_ST_RAM_TRAP] = ram_trap_enable;
        status[`WWAT_ST_STAGE_HI:`WWAT_ST_STAGE_LO] = cif.stage;
        status[`WWAT_ST_HOLD] = (rst_state == wwat_pkg::WWAT_RST_HOLD);
    end

    // read data registered with the ack; config and command read as zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0;
        end else if (bus_req && !wb_we_i && hit_idx(wb_adr_i, `WWAT_IDX_STATUS)) begin
            wb_dat_o <= {24'h0, status};
        end else begin
            wb_dat_o <= 32'h0;
        end
    end

    // ****************************************
    // config register
    // ****************************************
    // plain fields, reset leaves the watchdog on with reset action
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdog_on_bit <= CFG_RST[`WWAT_CFG_ON];
            detect_time_sel <= CFG_RST[`WWAT_CFG_TSEL_HI:`WWAT_CFG_TSEL_LO];
            trap_action_sel <= CFG_RST[`WWAT_CFG_TRAP_ACT];
            ram_trap_pending <= CFG_RST[`WWAT_CFG_RAM_TRAP];
        end else if (wr_cfg) begin
            wdog_on_bit <= wr_byte[`WWAT_CFG_ON];
            detect_time_sel <= wr_byte[`WWAT_CFG_TSEL_HI:`WWAT_CFG_TSEL_LO];
            trap_action_sel <= wr_byte[`WWAT_CFG_TRAP_ACT];
            ram_trap_pending <= wr_byte[`WWAT_CFG_RAM_TRAP];
        end
    end

    // once written to 0 the action stays interrupt until reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overflow_action_sel <= CFG_RST[`WWAT_CFG_ACT];
        end else if (wr_cfg) begin
            overflow_action_sel <= overflow_action_sel & wr_byte[`WWAT_CFG_ACT];
        end
    end

    // ****************************************
    // command register
    // ****************************************
    // enable follows the on bit, disable needs the code with the bit low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdog_running <= CFG_RST[`WWAT_CFG_ON];
        end else if (wr_cfg && wr_byte[`WWAT_CFG_ON]) begin
            wdog_running <= 1'b1;
        end else if (wr_cmd && (wr_byte == `WWAT_CODE_DISABLE) && !wdog_on_bit) begin
            wdog_running <= 1'b0;
        end
    end

    // clear code only restarts the binary stages
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clear_pulse <= 1'b0;
        end else begin
            clear_pulse <= wr_cmd && (wr_byte == `WWAT_CODE_CLEAR);
        end
    end

    // ram trap setting is live only after the commit code
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ram_trap_enable <= CFG_RST[`WWAT_CFG_RAM_TRAP];
        end else if (wr_cmd && (wr_byte == `WWAT_CODE_TRAP_COMMIT)) begin
            ram_trap_enable <= ram_trap_pending;
        end
    end

    // ****************************************
    // counter
    // ****************************************
    // pause in stop and idle mode; slow source per select or low-speed mode
    always_comb begin
        cif.count_en = !(stop_mode || idle_mode);
        cif.clear = clear_pulse;
        cif.running = wdog_running;
        cif.slow = slow_prescale_sel || low_speed_mode;
        cif.fs_tick = fs_tick;
        cif.tsel = detect_time_sel;
    end

    wwat_counter #(
        .DIV_W(DIV_W),
        .SLOW_SHIFT(SLOW_SHIFT)
    ) u_counter (
        .clk(clk),
        .rstn(rstn),
        .cif(cif)
    );

    // ****************************************
    // address trap
    // ****************************************
    logic trap_hit; // fetch from a trapping area

    // inclusive range check
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        trap_hit = fetch_valid && (in_range(16'(fetch_addr), SFR_LO, SFR_HI)
                   || in_range(16'(fetch_addr), DBR_LO, DBR_HI)
                   || (ram_trap_enable && in_range(16'(fetch_addr), RAM_LO, RAM_HI)));
    end

    // ****************************************
    // request pulses
    // ****************************************
    // no master flag input: both interrupts are non-maskable by design;
    // nesting and pending are the interrupt controller's job
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdog_irq <= 1'b0;
            wdog_rst_req <= 1'b0;
        end else begin
            wdog_irq <= cif.overflow && !overflow_action_sel;
            wdog_rst_req <= cif.overflow && overflow_action_sel;
        end
    end

    // one pulse per trapping fetch strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trap_irq <= 1'b0;
            trap_rst_req <= 1'b0;
        end else begin
            trap_irq <= trap_hit && !trap_action_sel;
            trap_rst_req <= trap_hit && trap_action_sel;
        end
    end

    // ****************************************
    // reset stretcher
    // ****************************************
    // holds the internal reset for a fixed 24 fc; a new request while
    // holding is absorbed so the length never exceeds the bound
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_state <= wwat_pkg::WWAT_RST_IDLE;
            rst_cnt <= 8'h0;
            sys_reset_out <= 1'b0;
        end else begin
            case (rst_state)
                wwat_pkg::WWAT_RST_IDLE: begin
                    if (wdog_rst_req || trap_rst_req) begin
                        rst_state <= wwat_pkg::WWAT_RST_HOLD;
                        rst_cnt <= 8'(`WWAT_RST_HOLD_CYC - 1);
                        sys_reset_out <= 1'b1;
                    end
                end
                wwat_pkg::WWAT_RST_HOLD: begin
                    if (rst_cnt == 8'h0) begin
                        rst_state <= wwat_pkg::WWAT_RST_IDLE;
                        sys_reset_out <= 1'b0;
                    end else begin
                        rst_cnt <= rst_cnt - 8'h1;
                    end
                end
                default: begin
                    rst_state <= wwat_pkg::WWAT_RST_IDLE;
                    sys_reset_out <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [7:0] hold_len; // consecutive reset-high cycles, helper only

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_len <= 8'h0;
        end else if (sys_reset_out) begin
            hold_len <= hold_len + 8'h1;
        end else begin
            hold_len <= 8'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ovf_to_irq: assert property (cif.overflow && !overflow_action_sel |=> wdog_irq && !wdog_rst_req)
        else $error("overflow in interrupt mode gave no interrupt");
    a_ovf_to_reset: assert property (cif.overflow && overflow_action_sel |=> wdog_rst_req ##1 sys_reset_out)
        else $error("overflow in reset mode gave no reset");
    a_action_oneway: assert property (!overflow_action_sel |=> !overflow_action_sel)
        else $error("action returned to reset");
    a_disable_gated: assert property (wr_cmd && wr_byte == `WWAT_CODE_DISABLE && wdog_on_bit
        && wdog_running |=> wdog_running) else $error("disable acted with on bit set");
    a_disable_stages: assert property (!wdog_running ##1 !wdog_running |-> cif.stage == 2'h0)
        else $error("stages not cleared while disabled");
    // routing follows the action bit that stood when the fetch was seen
    a_trap_route: assert property (trap_hit |=> (trap_irq != $past(trap_action_sel))
        && (trap_rst_req == $past(trap_action_sel))) else $error("trap routed wrongly");
    a_sfr_trap: assert property (fetch_valid && in_range(16'(fetch_addr), SFR_LO, SFR_HI)
        |=> trap_irq || trap_rst_req) else $error("special area fetch did not trap");
    // a second high cycle is legal only for a fresh event one cycle earlier
    a_pulse_single: assert property (wdog_irq || trap_irq |=> (!wdog_irq || $past(cif.overflow))
        && (!trap_irq || $past(trap_hit))) else $error("request longer than one cycle");
    a_reset_length: assert property (sys_reset_out |-> hold_len < 8'(`WWAT_RST_HOLD_CYC))
        else $error("internal reset held too long");
    a_commit_ram: assert property (wr_cmd && wr_byte == `WWAT_CODE_TRAP_COMMIT
        |=> ram_trap_enable == $past(ram_trap_pending)) else $error("ram trap commit lost");

    c_wdog_irq: cover property (wdog_irq);
    c_wdog_reset: cover property (wdog_rst_req ##1 sys_reset_out);
    c_trap_irq: cover property (trap_irq);
    c_disabled: cover property ($fell(wdog_running));
endmodule
`default_nettype wire

/* File: src/wwat_defs.svh */
// Purpose: named offsets, fields, codes and timing for the watchdog with address trap
// Assumes: included by bare name from design modules and the bench
// Notes: definitions only
`ifndef WWAT_DEFS_SVH
`define WWAT_DEFS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define WWAT_IDX_CONFIG 8'h34
`define WWAT_IDX_COMMAND 8'h35
`define WWAT_IDX_STATUS 8'h36
`define WWAT_IDX_W 8

// ****************************************
// config register fields
// ****************************************
`define WWAT_CFG_ACT 0
`define WWAT_CFG_TSEL_LO 1
`define WWAT_CFG_TSEL_HI 2
`define WWAT_CFG_ON 3
`define WWAT_CFG_TRAP_ACT 4
`define WWAT_CFG_RAM_TRAP 5
`define WWAT_CFG_RESET 8'h39

// ****************************************
// status register fields
// ****************************************
`define WWAT_ST_RUN 0
`define WWAT_ST_ACT 1
`define WWAT_ST_TRAP_ACT 2
`define WWAT_ST_RAM_TRAP 3
`define WWAT_ST_STAGE_LO 4
`define WWAT_ST_STAGE_HI 5
`define WWAT_ST_HOLD 6

// ****************************************
// command codes
// ****************************************
`define WWAT_CODE_CLEAR 8'h4e
`define WWAT_CODE_DISABLE 8'hb1
`define WWAT_CODE_TRAP_COMMIT 8'hd2

// ****************************************
// timing
// ****************************************
`define WWAT_CLK_PERIOD_NS 50
`define WWAT_FC_PERIOD_NS 50
`define WWAT_RST_FC_PERIODS 24
`define WWAT_RST_HOLD_CYC ((`WWAT_RST_FC_PERIODS * `WWAT_FC_PERIOD_NS) / `WWAT_CLK_PERIOD_NS)
`define WWAT_STAGE_TOP 2'h3

`endif

/* File: src/wwat_pkg.sv */
// Purpose: shared types of the watchdog with address trap
// Assumes: constants live in wwat_defs.svh
// Notes: no imports anywhere, use wwat_pkg::name
package wwat_pkg;
    // reset stretcher states
    typedef enum logic {
        WWAT_RST_IDLE,
        WWAT_RST_HOLD
    } wwat_rst_state_t;
    // counter stage width
    typedef logic [1:0] wwat_stage_t;
endpackage

/* File: src/wwat_cnt_if.sv */
// Purpose: carrier between the control logic and the divider/binary counter
// Assumes: one clock domain
// Notes: ctrl drives the counter, counter reports overflow and stage
`timescale 1ns/1ps
`default_nettype none
interface wwat_cnt_if;
    logic count_en; // low in stop and idle
    logic clear; // one-cycle clear of binary stages
    logic running; // watchdog enabled
    logic slow; // low-frequency source selected
    logic fs_tick; // one pulse per low-frequency period
    logic [1:0] tsel; // detection time select
    logic overflow; // one-cycle overflow pulse
    wwat_pkg::wwat_stage_t stage; // binary stages
    modport ctrl (output count_en, clear, running, slow, fs_tick, tsel, input overflow, stage);
    modport counter (input count_en, clear, running, slow, fs_tick, tsel, output overflow, stage);
endinterface
`default_nettype wire

/* File: src/wwat_counter.sv */
// Purpose: internal divider followed by a two-stage binary counter
// Assumes: fs_tick is synchronous to clk
// Notes: overflow after four divider ticks, i.e. 2^(exp+2) source periods
`timescale 1ns/1ps
`default_nettype none
`include "wwat_defs.svh"
module wwat_counter #(
    parameter int DIV_W = 23, // fast tick exponent for the longest time
    parameter int SLOW_SHIFT = 8 // fast/slow exponent difference
) (
    input wire logic clk,
    input wire logic rstn,
    wwat_cnt_if.counter cif
);
    // ****************************************
    // divider
    // ****************************************
    logic [DIV_W-1:0] divider; // free running, never cleared by software
    logic src_tick; // one source period elapsed
    logic tick; // divider tap carry
    logic [DIV_W:0] mask; // low bits that must be all ones

    // tap exponent from time select and source
    function automatic int tap_exp(input logic [1:0] sel, input logic slow);
        int e;
        e = DIV_W - 2 * int'(sel);
        if (slow) begin
            e = e - SLOW_SHIFT;
        end
        return e;
    endfunction

    always_comb begin
        src_tick = cif.slow ? cif.fs_tick : 1'b1;
        mask = (DIV_W+1)'((64'h1 << tap_exp(cif.tsel, cif.slow)) - 64'h1);
        tick = src_tick && cif.count_en && (({1'b0, divider} & mask) == mask);
    end

    // divider pauses with the low-power modes, keeps running otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divider <= '0;
        end else if (src_tick && cif.count_en) begin
            divider <= divider + 1'b1;
        end
    end

    // ****************************************
    // binary stages
    // ****************************************
    // clear and disable touch only the stages, not the divider
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cif.stage <= '0;
        end else if (!cif.running || cif.clear) begin
            cif.stage <= '0;
        end else if (tick) begin
            cif.stage <= cif.stage + 2'h1;
        end
    end

    // overflow pulse when the top stage wraps
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cif.overflow <= 1'b0;
        end else begin
            cif.overflow <= tick && cif.running && !cif.clear && (cif.stage == `WWAT_STAGE_TOP);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_clear_stage: assert property (cif.clear |=> cif.stage == 2'h0) else $error("clear left stages set");
    a_hold_count: assert property (!cif.count_en && cif.running && !cif.clear |=> $stable(cif.stage))
        else $error("stages moved while paused");
endmodule
`default_nettype wire

/* File: test/tb_wwat_top.sv */
// Purpose: self-checking bench for the watchdog with address trap
// Assumes: divider shortened to 12 bits, fc equal to clk, fs pulse every second cycle
// Notes: overflow windows are worked out from divider period and four binary ticks
`timescale 1ns/1ps
`default_nettype none
`include "wwat_defs.svh"
module tb_wwat_top;
    // ********
    // signals and design
    // ********
    localparam int DW = 12; // shortened divider, fast tick every 2^(DW-2*sel)
    logic clk, rstn, cyc, stb, we, slow, lsm, fst, stp, idl, fv, ack, sro;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rdo, rd;
    logic [15:0] fa;
    logic [3:0] reqs; // trap reset, trap irq, wdog reset, wdog irq
    int fails, check_count, now, t0, p;
    int m_tact = 1, m_rpend = 1, m_ron = 1; // trap model state, reset values from the rules
    int exp_q[$]; // model expectation per fetch
    wwat_top #(.DIV_W(DW), .SLOW_SHIFT(2)) wwat_top_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdo),
        .wb_ack_o(ack), .slow_prescale_sel(slow), .low_speed_mode(lsm), .fs_tick(fst), .stop_mode(stp),
        .idle_mode(idl), .fetch_valid(fv), .fetch_addr(fa), .wdog_irq(reqs[0]), .wdog_rst_req(reqs[1]),
        .trap_irq(reqs[2]), .trap_rst_req(reqs[3]), .sys_reset_out(sro));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // cycle count for windows; fs pulse only matters while slow source is chosen
    always @(posedge clk) begin
        now <= now + 1;
        fst <= ~fst;
    end
    // ********
    // shared tasks
    // ********
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic done(string s);
        $display("test %s done", s);
    endtask
    // one classic cycle; data taken at the ack edge, then one idle cycle
    task automatic bus(logic w, logic [7:0] idx, logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        check("ack", ack, 1'h1);
        rd = rdo;
        if (w && idx == `WWAT_IDX_CONFIG) begin
            m_tact = d[`WWAT_CFG_TRAP_ACT];
            m_rpend = d[`WWAT_CFG_RAM_TRAP];
        end
        if (w && idx == `WWAT_IDX_COMMAND && d == `WWAT_CODE_TRAP_COMMIT) m_ron = m_rpend;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask
    // request k alone, elapsed since t0 within lo..hi, then gone
    task automatic wait_req(int k, int lo, int hi);
        int el;
        el = 0;
        while (reqs === 4'h0 && el < hi + 20) begin
            @(posedge clk);
            el = now - t0;
        end
        check("request", reqs, 4'h1 << k);
        check("window", el >= lo && el <= hi, 1);
        @(posedge clk);
        check("pulse end", reqs, 4'h0);
    endtask
    // stretched reset level length; rise may lag by up to three cycles
    task automatic hold_len();
        int n;
        n = 0;
        repeat (3) if (sro !== 1'h1) @(posedge clk);
        while (sro === 1'h1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check("hold", n, `WWAT_RST_HOLD_CYC);
    endtask
    task automatic quiet(int n);
        logic [3:0] seen;
        seen = 4'h0;
        repeat (n) begin
            @(posedge clk);
            seen |= reqs;
        end
        check("quiet", seen, 4'h0);
    endtask
    // one fetch strobe, answer expected one cycle later
    task automatic fetch(logic [15:0] a, logic [3:0] exp);
        exp_q.push_back((a <= 16'h3f || (a >= 16'hf80 && a <= 16'hfff) || (m_ron && a >= 16'h40 && a <= 16'h43f))
            ? (m_tact ? 8 : 4) : 0); // areas are the design's default ranges
        fv <= 1'h1;
        fa <= a;
        @(posedge clk);
        fv <= 1'h0;
        @(posedge clk);
        check("trap", reqs, exp);
        check("trap model", reqs, exp_q.pop_front());
        @(posedge clk);
        check("pulse end", reqs, 4'h0);
        if (exp[3]) hold_len();
    endtask
    // ********
    // tests
    // ********
    initial begin
        {cyc, stb, we, slow, lsm, stp, idl, fv, fst, rstn} = 10'h0;
        sel = 4'h1;
        adr = 10'h0;
        wd = 32'h0;
        fa = 16'h0;
        void'($urandom(32'hc74a8c3a));
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        check("outputs", {sro, reqs}, 5'h0);
        bus(1'h0, `WWAT_IDX_STATUS, 8'h0);
        check("status", rd & 32'h4f, 32'h0f);
        bus(1'h0, `WWAT_IDX_CONFIG, 8'h0);
        check("config read", rd, 32'h0);
        bus(1'h0, 8'h3f, 8'h0);
        check("unmapped", rd, 32'h0);
        done("reset");
        // every detect time with reset action and its stretched level
        for (int s = 0; s < 4; s++) begin
            p = 1 << (DW - 2 * s);
            bus(1'h1, `WWAT_IDX_CONFIG, 8'h39 | 8'(s << 1));
            bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_CLEAR);
            t0 = now;
            wait_req(1, 3 * p - 2, 4 * p + 4);
            hold_len();
        end
        done("detect");
        repeat (4) begin
            bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_CLEAR);
            quiet($urandom_range(140, 100));
        end
        done("keepalive");
        // interrupt action sticks; back to back overflows each raise it
        bus(1'h1, `WWAT_IDX_CONFIG, 8'h3e);
        bus(1'h1, `WWAT_IDX_CONFIG, 8'h3f);
        bus(1'h0, `WWAT_IDX_STATUS, 8'h0);
        check("action", rd[1], 1'h0);
        bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_CLEAR);
        t0 = now;
        wait_req(0, 3 * p - 2, 4 * p + 4);
        t0 = now;
        wait_req(0, 4 * p - 3, 4 * p + 1);
        done("interrupt");
        for (int m = 0; m < 2; m++) begin
            bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_CLEAR);
            {idl, stp} <= 2'(1 << m);
            quiet(5 * p);
            {idl, stp} <= 2'h0;
            t0 = now;
            wait_req(0, 3 * p - 4, 4 * p + 4);
        end
        done("pause");
        // slow source ticks every 32 cycles here, through either select
        for (int m = 0; m < 2; m++) begin
            {lsm, slow} <= 2'(1 << m);
            bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_CLEAR);
            t0 = now;
            wait_req(0, 6 * p / 4 - 6, 2 * p + 8);
        end
        {lsm, slow} <= 2'h0;
        done("slow");
        bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_DISABLE);
        bus(1'h1, `WWAT_IDX_COMMAND, 8'h5a);
        bus(1'h0, `WWAT_IDX_STATUS, 8'h0);
        check("running", rd[0], 1'h1);
        bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_CLEAR);
        bus(1'h1, `WWAT_IDX_CONFIG, 8'h36);
        bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_DISABLE);
        bus(1'h0, `WWAT_IDX_STATUS, 8'h0);
        check("stopped", rd[5:0] & 6'h31, 6'h0);
        quiet(6 * p);
        done("disable");
        // trap areas, ram select commit, routing by trap action
        fetch(16'($urandom_range(16'h3f, 16'h0)), 4'h8);
        fetch(16'($urandom_range(16'h43f, 16'h40)), 4'h8);
        bus(1'h1, `WWAT_IDX_CONFIG, 8'h16);
        fetch(16'h0040, 4'h8);
        bus(1'h1, `WWAT_IDX_COMMAND, `WWAT_CODE_TRAP_COMMIT);
        fetch(16'h043f, 4'h0);
        fetch(16'h0fff, 4'h8);
        bus(1'h1, `WWAT_IDX_CONFIG, 8'h06);
        fetch(16'($urandom_range(16'hfff, 16'hf80)), 4'h4);
        fetch(16'h003f, 4'h4);
        fetch(16'h1000, 4'h0);
        done("traps");
        close_out();
    end
    // hang guard, well past the longest detect time plus the rest
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
`default_nettype wire
